// ==== test/scr_host_model.sv ====
// Purpose: Host side of the three-wire serial port
// Assumes: Serial clock half period of four core_clk cycles (800 ns period)
// Notes: Data line shows the inverse of its last bit between frames
`timescale 1ns/1ps
module scr_host_model
    import scr_pkg::*;
(
    input wire logic core_clk,
    output logic sdata,
    output logic sclk,
    output logic strobe
);
    initial
    begin
        sdata = 1'b0;
        sclk = 1'b0;
        strobe = 1'b1;
    end

    task automatic half();
        repeat (4) @(posedge core_clk);
    endtask

    // Clock low outside frames; an init group keeps it high past the strobe
    task automatic send(input logic [23:0] v, input int n, input bit init = 1'b0);
        @(posedge core_clk);
        strobe <= 1'b0;
        half();
        for (int i = n - 1; i >= 0; i--)
        begin
            sdata <= v[i];
            half();
            sclk <= 1'b1;
            half();
            if (i > 0 || !init)
                sclk <= 1'b0;
        end
        half();
        strobe <= 1'b1;
        sdata <= ~sdata;
        half();
        sclk <= 1'b0;
        half();
    endtask
endmodule

// ==== test/scr_synth_ctrl_tb_top.sv ====
// Purpose: Self-checking bench of the synthesizer control block
// Assumes: Reference input period of 16 core_clk cycles
// Notes: Ratios are judged by periods of the divided outputs
`timescale 1ns/1ps
module scr_synth_ctrl_tb_top
    import scr_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reference_input = 1'b0;
    logic feedback_divided_pulse = 1'b0;
    logic [2:0] ref_cnt = 3'h0;
    wire sdata, sclk, strobe;
    logic reference_output, reference_divided_pulse, ref_input_enable, ref_feedback_connect;
    logic counters_enable, current_resistor_en, pump_up, pump_dn, pump_oe;
    logic phase_r_out, phase_v_out, lock_out, push_pull_out, open_drain_out, open_drain_oe;
    logic [23:0] freq_word;
    logic [6:0] pump_pct;
    logic [23:0] n;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    localparam logic [6:0] FINE[4] = '{7'h46, 7'h50, 7'h5a, 7'h64};
    localparam logic [6:0] COARSE[4] = '{7'h19, 7'h32, 7'h4b, 7'h64};

    scr_host_model scr_host_model_i (.core_clk(core_clk), .sdata(sdata), .sclk(sclk),
        .strobe(strobe));
    scr_synth_ctrl scr_synth_ctrl_i (.core_clk(core_clk), .rst_n(rst_n),
        .serial_data_in(sdata), .serial_clock_in(sclk), .serial_load_strobe(strobe),
        .reference_input(reference_input), .feedback_divided_pulse(feedback_divided_pulse),
        .reference_output(reference_output), .reference_divided_pulse(reference_divided_pulse),
        .ref_input_enable(ref_input_enable), .ref_feedback_connect(ref_feedback_connect),
        .counters_enable(counters_enable), .current_resistor_en(current_resistor_en),
        .freq_word(freq_word), .charge_pump_output_up(pump_up),
        .charge_pump_output_dn(pump_dn), .charge_pump_output_oe(pump_oe),
        .pump_pct(pump_pct), .phase_r_out(phase_r_out), .phase_v_out(phase_v_out),
        .lock_indicator_output(lock_out), .push_pull_out(push_pull_out),
        .open_drain_out(open_drain_out), .open_drain_oe(open_drain_oe));

    always #50 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk)
    begin
        ref_cnt <= ref_cnt + 3'h1;
        if (ref_cnt == 3'h7)
            reference_input <= ~reference_input;
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks_done %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic put(input logic [23:0] v, input int bits, input bit init = 1'b0);
        scr_host_model_i.send(v, bits, init);
        #1;
    endtask

    // Cycles between two rises; zero when the output stands still
    task automatic period(input logic sel);
        logic p;
        logic c;
        int k;
        n = 24'h0;
        p = 1'b1;
        k = 0;
        for (int g = 0; g < 700 && k < 2; g++)
        begin
            @(posedge core_clk);
            #1;
            c = sel ? reference_divided_pulse : reference_output;
            if (k == 1)
                n = n + 24'h1;
            if (c && !p)
                k++;
            p = c;
        end
        if (k < 2)
            n = 24'h0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("lock", 24'h0, lock_out);
        chk("phase_r", 24'h1, phase_r_out);
        chk("phase_v", 24'h1, phase_v_out);
        chk("od_oe", 24'h1, open_drain_oe);
        chk("od_out", 24'h0, open_drain_out);
        chk("pct", 24'h46, pump_pct);
        period(1'b0);
        chk("ref_div8", 24'h80, n);
    endtask

    task automatic t_pump();
        for (int s = 0; s < 2; s++)
            for (int c = 0; c < 4; c++)
            begin
                put({16'h0, 4'h0, 2'(c), 1'(s), 1'b1}, 8);
                chk("pct", s ? COARSE[c] : FINE[c], pump_pct);
                chk("od_oe", 24'h0, open_drain_oe);
            end
    endtask

    task automatic t_refmode();
        put({8'h0, 3'h7, 13'h0001}, 16);
        period(1'b0);
        chk("ref_div16", 24'h100, n);
        put({8'h0, 3'h3, 13'h0001}, 16);
        period(1'b0);
        chk("ref_direct", 24'h10, n);
        put({8'h0, 3'h2, 13'h0001}, 16);
        period(1'b0);
        chk("ref_off", 24'h0, {n[23:1], reference_output});
    endtask

    task automatic t_ratio();
        put({8'h0, 3'h3, 13'h0005}, 16);
        period(1'b1);
        chk("ratio_held", 24'h10, n);
        put(24'h0, 0);
        period(1'b1);
        chk("ratio_moved", 24'h50, n);
        put({8'h0, 3'h3, 13'h0002}, 16);
        put(24'hc01234, 24);
        chk("freq", 24'hc01234, freq_word);
        period(1'b1);
        chk("ratio_freq", 24'h20, n);
    endtask

    task automatic t_port();
        put(24'h0a, 8);
        chk("port_hi", 24'h1, push_pull_out);
        chk("pct_port", 24'h5a, pump_pct);
        put(24'h08, 8);
        chk("port_lo", 24'h0, push_pull_out);
        repeat (3) put(24'h1f, 5, 1'b1);
        chk("short", 24'h5a, pump_pct);
    endtask

    task automatic t_low_power_hold();
        put({8'h0, 3'h0, 13'h0005}, 16);
        put(24'h70, 8);
        chk("cnt_en", 24'h0, {counters_enable, current_resistor_en});
        chk("pump_oe", 24'h0, pump_oe);
        chk("phases", 24'h3, {phase_r_out, phase_v_out});
        chk("lock_low_power_hold", 24'h1, lock_out);
        chk("ref_in", 24'h0, {ref_input_enable, ref_feedback_connect});
        chk("freq_kept", 24'hc01234, freq_word);
        put(24'h40, 8);
        chk("cnt_run", 24'h3, {counters_enable, current_resistor_en});
        chk("ref_back", 24'h3, {ref_input_enable, ref_feedback_connect});
        chk("pump_sel", 24'h1, pump_oe);
        @(posedge core_clk);
        feedback_divided_pulse <= 1'b1;
        @(posedge core_clk);
        feedback_divided_pulse <= 1'b0;
        // Only 16-bit, 8-bit and 5-bit accesses ran since the last move, so the active ratio is still two
        period(1'b1);
        chk("jam_run", 24'h20, n);
        // Reference pulses with no feedback pulse: source side stays on
        chk("pump_src", 24'h2, {pump_up, pump_dn});
        put(24'hc0, 8);
        chk("pump_pol", 24'h1, {pump_up, pump_dn});
    endtask

    initial
    begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        t_reset();
        t_pump();
        t_refmode();
        t_ratio();
        t_port();
        t_low_power_hold();
        end_of_test();
    end
endmodule

// ==== verilog/scr_pin_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for pins
// Assumes: Inputs are asynchronous to core_clk
// Notes: Output changes only when stages two and three agree
`timescale 1ns/1ps
module scr_pin_sync
    import scr_pkg::*;
#(
    parameter int W = 4
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);

    logic [W-1:0] ff1_reg;
    logic [W-1:0] ff2_reg;
    logic [W-1:0] ff3_reg;

    genvar gi;
    generate
        for (gi = 0; gi < W; gi++)
        begin : g_lane
            always_ff @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    ff1_reg[gi] <= PIN_IDLE[gi];
                    ff2_reg[gi] <= PIN_IDLE[gi];
                    ff3_reg[gi] <= PIN_IDLE[gi];
                    level_out[gi] <= PIN_IDLE[gi];
                end
                else
                begin
                    ff1_reg[gi] <= pin_in[gi];
                    ff2_reg[gi] <= ff1_reg[gi];
                    ff3_reg[gi] <= ff2_reg[gi];
                    if (ff2_reg[gi] == ff3_reg[gi])
                        level_out[gi] <= ff3_reg[gi];
                end
            end
        end
    endgenerate

endmodule

// ==== verilog/scr_pkg.sv ====
// Purpose: Shared constants and types of the synthesizer control block
// Assumes: Bit counts and register fields as the serial port defines them
// Notes: Field positions, lengths and the serial registers' reset values live here only
package scr_pkg;

    // Serial access lengths in clock cycles; LEN_SAT is where the bit count stops
    localparam logic [4:0] LEN_SWAP = 5'h00;
    localparam logic [4:0] LEN_CFG = 5'h08;
    localparam logic [4:0] LEN_REF = 5'h10;
    localparam logic [4:0] LEN_FREQ = 5'h18;
    localparam logic [4:0] LEN_SAT = 5'h1f;

    localparam int SHIFT_W = 24;
    localparam int CFG_W = 8;
    localparam int RATIO_W = 13;
    localparam int MODE_LSB = 13;
    localparam int MODE_MSB = 15;
    localparam int PORT_LSB = 22;
    localparam int PORT_MSB = 23;
    localparam int PCT_W = 7;

    // Frequency-register code that turns the push-pull output into a port
    localparam logic [1:0] PORT_SEL = 2'h3;

    // Reference output modes
    localparam logic [2:0] MODE_LOW = 3'h0;
    localparam logic [2:0] MODE_HIGH = 3'h1;
    localparam logic [2:0] MODE_OFF = 3'h2;
    localparam logic [2:0] MODE_DIRECT = 3'h3;
    localparam logic [2:0] MODE_RST = 3'h6;

    localparam logic [12:0] RATIO_RST = 13'h0001;
    localparam logic [12:0] CNT_LAST = 13'h0001;
    localparam logic [23:0] FREQ_RST = 24'h000000;
    localparam logic [3:0] DIV_STEP = 4'h1;
    localparam logic [4:0] BIT_STEP = 5'h01;

    // Pump current in percent, code 0 in the low slice
    localparam logic [27:0] PCT_FINE = {7'h64, 7'h5a, 7'h50, 7'h46};
    localparam logic [27:0] PCT_COARSE = {7'h64, 7'h4b, 7'h32, 7'h19};

    // Pin synchroniser lanes
    localparam int PIN_DATA = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_STRB = 2;
    localparam int PIN_REF = 3;
    localparam int PIN_COUNT = 4;
    // Idle level per lane; strobe rests high, so reset must not fake a rise
    localparam logic [PIN_COUNT-1:0] PIN_IDLE = 4'h4;

    typedef struct packed {
        logic detector_polarity_invert;
        logic detector_select;
        logic lock_indicator_enable;
        logic low_power_hold;
        logic pump_current_hi_bit;
        logic pump_current_lo_bit;
        logic port_bit;
        logic outb_float;
    } scr_cfg_s;

    localparam scr_cfg_s CFG_RST = scr_cfg_s'(8'h00);

    typedef struct packed {
        logic pump_up;
        logic pump_dn;
        logic pump_oe;
        logic phase_r;
        logic phase_v;
        logic lock;
        logic push_pull;
        logic od_oe;
        logic ref_out;
        logic [6:0] pct;
    } scr_pins_s;

    // Phases at rest, open-drain pulling low, fine step code 0
    localparam scr_pins_s PINS_RST = scr_pins_s'(16'h1946);

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_HOLD = 2'b01,
        ST_WAIT_FV = 2'b10
    } scr_exit_e;

endpackage

// ==== verilog/scr_ref_count.sv ====
// Purpose: 13-stage reference down-counter with jam load
// Assumes: tick is a one-cycle pulse per reference edge
// Notes: A new ratio is taken at the end of a count cycle or at once on a jam load
`timescale 1ns/1ps
module scr_ref_count
    import scr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic run,
    input wire logic jam,
    input wire logic [12:0] ratio,
    output logic pulse_reg
);

    logic [12:0] count_reg;
    logic [12:0] count_next;
    logic wrap;

    assign wrap = run && tick && (count_reg <= CNT_LAST);
    assign count_next = jam ? ratio
                      : wrap ? ratio
                      : (run && tick) ? count_reg - CNT_LAST
                      : count_reg;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_reg <= RATIO_RST;
            pulse_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            pulse_reg <= wrap && !jam;
        end
    end

endmodule

// ==== verilog/scr_synth_ctrl.sv ====
// Purpose: Configuration and reference registers of a PLL synthesizer
// Assumes: Host drives data, clock and load strobe; core_clk samples all
// Notes: Frequency counters are outside; they follow counters_enable
`timescale 1ns/1ps
module scr_synth_ctrl
    import scr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic serial_data_in,
    input wire logic serial_clock_in,
    input wire logic serial_load_strobe,
    input wire logic reference_input,
    input wire logic feedback_divided_pulse,
    output logic reference_output,
    output logic reference_divided_pulse,
    output logic ref_input_enable,
    output logic ref_feedback_connect,
    output logic counters_enable,
    output logic current_resistor_en,
    output logic [23:0] freq_word,
    output logic charge_pump_output_up,
    output logic charge_pump_output_dn,
    output logic charge_pump_output_oe,
    output logic [6:0] pump_pct,
    output logic phase_r_out,
    output logic phase_v_out,
    output logic lock_indicator_output,
    output logic push_pull_out,
    output logic open_drain_out,
    output logic open_drain_oe
);

    ////////////////////////////////////////////////////////////////////
    // Pin sampling

    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_lvl;
    logic sclk_d_reg;
    logic strb_d_reg;
    logic ref_d_reg;
    logic sclk_rise;
    logic strb_rise;
    logic ref_rise;

    assign pin_raw = {reference_input, serial_load_strobe, serial_clock_in, serial_data_in};

    scr_pin_sync #(.W(PIN_COUNT)) u_sync
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin_in(pin_raw),
        .level_out(pin_lvl)
    );

    assign sclk_rise = pin_lvl[PIN_SCLK] && !sclk_d_reg;
    assign strb_rise = pin_lvl[PIN_STRB] && !strb_d_reg;
    assign ref_rise = pin_lvl[PIN_REF] && !ref_d_reg;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_d_reg <= 1'b0;
            strb_d_reg <= 1'b1;
            ref_d_reg <= 1'b0;
        end
        else
        begin
            sclk_d_reg <= pin_lvl[PIN_SCLK];
            strb_d_reg <= pin_lvl[PIN_STRB];
            ref_d_reg <= pin_lvl[PIN_REF];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Serial shifter and load decode

    logic [SHIFT_W-1:0] shift_reg;
    logic [4:0] bit_cnt_reg;
    logic [4:0] bit_cnt_next;
    logic shift_en;
    logic load_cfg;
    logic load_ref;
    logic load_freq;
    logic swap_buf;

    assign shift_en = sclk_rise && !pin_lvl[PIN_STRB];
    assign bit_cnt_next = strb_rise ? LEN_SWAP
                        : (shift_en && bit_cnt_reg != LEN_SAT) ? bit_cnt_reg + BIT_STEP
                        : bit_cnt_reg;

    // Any other count, including five-bit init groups, is dropped
    assign load_cfg = strb_rise && bit_cnt_reg == LEN_CFG;
    assign load_ref = strb_rise && bit_cnt_reg == LEN_REF;
    assign load_freq = strb_rise && bit_cnt_reg == LEN_FREQ;
    // Strobe with no clocks relies on the host holding clock low
    assign swap_buf = strb_rise && bit_cnt_reg == LEN_SWAP;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_reg <= FREQ_RST;
            bit_cnt_reg <= LEN_SWAP;
        end
        else
        begin
            if (shift_en)
                shift_reg <= {shift_reg[SHIFT_W-2:0], pin_lvl[PIN_DATA]};
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers; standby never touches them

    scr_cfg_s cfg_reg;
    logic [2:0] ref_mode_reg;
    logic [12:0] ref_buf1_reg;
    logic [12:0] ref_buf2_reg;
    logic [23:0] freq_reg;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_reg <= CFG_RST;
            ref_mode_reg <= MODE_RST;
            ref_buf1_reg <= RATIO_RST;
            ref_buf2_reg <= RATIO_RST;
            freq_reg <= FREQ_RST;
        end
        else
        begin
            // Loads only; low_power_hold has no path here
            if (load_cfg)
                cfg_reg <= scr_cfg_s'(shift_reg[CFG_W-1:0]);
            if (load_ref)
            begin
                ref_mode_reg <= shift_reg[MODE_MSB:MODE_LSB];
                ref_buf1_reg <= shift_reg[RATIO_W-1:0];
            end
            if (load_freq)
                freq_reg <= shift_reg;
            if (swap_buf || load_freq)
                ref_buf2_reg <= ref_buf1_reg;
        end
    end

    assign freq_word = freq_reg;

    ////////////////////////////////////////////////////////////////////
    // Standby entry and two-step exit

    scr_exit_e state_reg;
    scr_exit_e state_next;
    logic hold;
    logic fv;
    logic jam;
    logic counters_run;
    logic gate_open;

    assign hold = cfg_reg.low_power_hold;
    assign fv = feedback_divided_pulse;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RUN:
                if (hold)
                    state_next = ST_HOLD;
            ST_HOLD:
                if (!hold)
                    state_next = ST_WAIT_FV;
            ST_WAIT_FV:
                if (hold)
                    state_next = ST_HOLD;
                else if (fv)
                    state_next = ST_RUN;
            default:
                state_next = ST_HOLD;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= ST_RUN;
        else
            state_reg <= state_next;
    end

    assign jam = state_reg == ST_WAIT_FV && fv && !hold;
    assign counters_run = state_reg != ST_HOLD;
    assign gate_open = state_reg == ST_RUN;
    assign counters_enable = counters_run;
    assign current_resistor_en = counters_run;

    ////////////////////////////////////////////////////////////////////
    // Reference oscillator, output divider and 13-stage counter

    logic ref_active;
    logic ref_tick;
    logic [3:0] div_cnt_reg;
    logic reference_output_next;
    logic fr;

    // Only the static-low mode shuts the input down in standby
    assign ref_active = !(state_reg == ST_HOLD && ref_mode_reg == MODE_LOW);
    assign ref_tick = ref_rise && ref_active;
    assign ref_input_enable = ref_active;
    assign ref_feedback_connect = ref_active;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            div_cnt_reg <= 4'h0;
        else if (ref_tick)
            div_cnt_reg <= div_cnt_reg + DIV_STEP;
    end

    // Modes four to seven tap divide by 2, 4, 8 and 16
    assign reference_output_next = (ref_mode_reg == MODE_LOW) ? 1'b0
                       : (ref_mode_reg == MODE_HIGH) ? 1'b1
                       : (ref_mode_reg == MODE_OFF) ? 1'b0
                       : (ref_mode_reg == MODE_DIRECT) ? pin_lvl[PIN_REF]
                       : div_cnt_reg[ref_mode_reg[1:0]];

    scr_ref_count u_rcnt
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .tick(ref_tick),
        .run(counters_run),
        .jam(jam),
        .ratio(ref_buf2_reg),
        .pulse_reg(fr)
    );

    assign reference_divided_pulse = fr;

    ////////////////////////////////////////////////////////////////////
    // Phase/frequency detector

    logic up_reg;
    logic dn_reg;
    logic up_next;
    logic dn_next;
    logic src;
    logic snk;

    // Both set clears both: the short in-phase pulse on the pair
    assign up_next = gate_open && !(up_reg && dn_reg) && (up_reg || fr);
    assign dn_next = gate_open && !(up_reg && dn_reg) && (dn_reg || fv);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            up_reg <= 1'b0;
            dn_reg <= 1'b0;
        end
        else
        begin
            up_reg <= up_next;
            dn_reg <= dn_next;
        end
    end

    assign src = cfg_reg.detector_polarity_invert ? dn_reg : up_reg;
    assign snk = cfg_reg.detector_polarity_invert ? up_reg : dn_reg;

    ////////////////////////////////////////////////////////////////////
    // Output selection, registered at the pins

    logic single_on;
    logic dual_on;
    logic port_mode;
    logic [1:0] cur_code;
    logic [27:0] pct_table;
    scr_pins_s pins_next;
    scr_pins_s pins_reg;

    assign single_on = cfg_reg.detector_select && !hold;
    assign dual_on = !cfg_reg.detector_select && !hold;
    assign port_mode = freq_reg[PORT_MSB:PORT_LSB] == PORT_SEL;
    assign cur_code = {cfg_reg.pump_current_hi_bit, cfg_reg.pump_current_lo_bit};
    // Port mode borrows the step bit, so the fine table is forced
    assign pct_table = (cfg_reg.port_bit && !port_mode) ? PCT_COARSE
                     : PCT_FINE;

    assign pins_next.pump_up = single_on && src;
    assign pins_next.pump_dn = single_on && snk;
    assign pins_next.pump_oe = single_on;
    assign pins_next.phase_r = dual_on ? !src : 1'b1;
    assign pins_next.phase_v = dual_on ? !snk : 1'b1;
    assign pins_next.lock = !cfg_reg.lock_indicator_enable ? 1'b0
                          : hold ? 1'b1
                          : !src && !snk;
    assign pins_next.push_pull = port_mode ? cfg_reg.port_bit : fr;
    assign pins_next.od_oe = !cfg_reg.outb_float;
    assign pins_next.ref_out = reference_output_next;
    assign pins_next.pct = pct_table[{cur_code, 3'h0} - {3'h0, cur_code} +: PCT_W];

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            pins_reg <= PINS_RST;
        else
            pins_reg <= pins_next;
    end

    assign charge_pump_output_up = pins_reg.pump_up;
    assign charge_pump_output_dn = pins_reg.pump_dn;
    assign charge_pump_output_oe = pins_reg.pump_oe;
    assign phase_r_out = pins_reg.phase_r;
    assign phase_v_out = pins_reg.phase_v;
    assign lock_indicator_output = pins_reg.lock;
    assign push_pull_out = pins_reg.push_pull;
    assign open_drain_out = 1'b0;
    assign open_drain_oe = pins_reg.od_oe;
    assign reference_output = pins_reg.ref_out;
    assign pump_pct = pins_reg.pct;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_cfg_byte_load: assert property (
        load_cfg |=> cfg_reg == $past(shift_reg[CFG_W-1:0]) && freq_reg == $past(freq_reg))
        else $error("Configuration byte not stored alone");

    a_ref_mode_now: assert property (
        load_ref |=> ref_mode_reg == $past(shift_reg[MODE_MSB:MODE_LSB])
            && ref_buf2_reg == $past(ref_buf2_reg))
        else $error("Reference load touched the active ratio");

    a_buf_swap_move: assert property (
        swap_buf |=> ref_buf2_reg == $past(ref_buf1_reg))
        else $error("Extra strobe did not move ratio");

    a_freq_swap_move: assert property (
        load_freq |=> ref_buf2_reg == $past(ref_buf1_reg) && freq_reg == $past(shift_reg))
        else $error("Frequency load did not move ratio");

    a_lock_off_low: assert property (
        !cfg_reg.lock_indicator_enable |=> !lock_indicator_output)
        else $error("Lock output not low while disabled");

    a_hold_lock_high: assert property (
        hold && cfg_reg.lock_indicator_enable |=> lock_indicator_output)
        else $error("Lock output not high in standby");

    a_hold_rest_outs: assert property (
        hold ##1 hold |-> !charge_pump_output_oe && phase_r_out && phase_v_out
            && !counters_enable)
        else $error("Standby outputs not at rest");

    a_wait_gate_shut: assert property (
        state_reg == ST_WAIT_FV |-> !up_reg && !dn_reg && counters_enable)
        else $error("Detector pulses passed before jam load");

    a_jam_resume_run: assert property (
        jam |=> state_reg == ST_RUN ##1 gate_open)
        else $error("Jam load did not resume detectors");

    a_port_pct_fine: assert property (
        port_mode && cur_code == 2'h0 |=> pump_pct == PCT_FINE[PCT_W-1:0])
        else $error("Port mode did not force fine current steps");

    a_outb_float_bit: assert property (
        $rose(cfg_reg.outb_float) |=> !open_drain_oe)
        else $error("Open-drain output not floated");

    c_cfg_load: cover property (load_cfg);
    c_buf_swap: cover property (swap_buf);
    c_hold_exit: cover property (state_reg == ST_WAIT_FV ##[1:1000] jam);
    c_freq_load: cover property (load_freq);

endmodule
